//--- hdl/sdbk_ctrl.sv
// Device-wide command decode and clock-enable state control for a four-bank DRAM.
// Assumes command pins and clock enable come from outside the clock domain.
//
// Contract
// - Write recovery: quiet commands wait, then active
// - Recovery with close: precharge, halt returns active
// - Refresh: quiet commands only, idle after cycle
// - Mode load: idle after two clocks, quiet only
// - Commands act only with clock enable held high
// - All idle, enable low: power-down, inputs off
// - All idle, refresh command with enable falling: self-refresh
// - Self-refresh held low; exit via recovery, row cycle
// - Busy with enable low: clock suspend
// - Power-down ends when enable rises
// - All idle, refresh command: auto refresh
// - Rising enable reopens inputs at once
// - Closing: quiet commands wait, then idle
`timescale 1ns/1ps
module sdbk_ctrl #(
  parameter int NUM_BANKS = sdbk_pkg::NUM_BANKS
) (
  // Clock and reset
  input  wire logic                             mclk_i,
  input  wire logic                             nrst_i,
  // Command pins
  input  wire logic                             cke_i,
  input  wire logic                             cs_n_i,
  input  wire logic                             ras_n_i,
  input  wire logic                             cas_n_i,
  input  wire logic                             we_n_i,
  input  wire logic [sdbk_pkg::BANK_W-1:0]      ba_i,
  input  wire logic                             auto_close_flag_pin_i,
  // Status
  output logic [NUM_BANKS*sdbk_pkg::ST_W-1:0]   bank_state_o,
  output sdbk_pkg::sdbk_dev_st_t                dev_state_o,
  output logic                                  input_buf_en_o,
  output logic                                  clock_suspend_o,
  output logic                                  illegal_cmd_o
);

  localparam int RC_BACK = sdbk_pkg::RC_CYC;
  localparam logic [sdbk_pkg::TMR_W-1:0] RC_LOAD = sdbk_pkg::TMR_W'(sdbk_pkg::RC_CYC - 1);
  localparam logic [sdbk_pkg::TMR_W-1:0] ML_LOAD =
    sdbk_pkg::TMR_W'(sdbk_pkg::MODE_LOAD_CYC - 1);

  // Pin synchroniser: first stage read only by second
  logic [7:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
  logic       cke_prev_q, cke_prev_d;

  always_comb begin
    pin_s1_d   = {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, auto_close_flag_pin_i};
    pin_s2_d   = pin_s1_q;
    cke_prev_d = pin_s2_q[7];
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pin_s1_q   <= 8'hFF;
      pin_s2_q   <= 8'hFF;
      cke_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= pin_s1_d;
      pin_s2_q   <= pin_s2_d;
      cke_prev_q <= cke_prev_d;
    end
  end

  sdbk_pkg::sdbk_dev_st_t dev_q, dev_d;
  logic [sdbk_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic                       ill_q, ill_d;
  logic                       cke_cur;
  logic                       ck_both;
  logic                       ck_fall;
  logic                       buf_en;
  logic                       all_idle;
  logic                       bank_run;
  logic                       bank_tick;
  sdbk_pkg::sdbk_cmd_t        cmd;
  logic [NUM_BANKS-1:0]       bank_idle;
  logic [NUM_BANKS-1:0]       bank_ill;

  assign cke_cur = pin_s2_q[7];
  assign ck_both = cke_prev_q && cke_cur;
  assign ck_fall = cke_prev_q && !cke_cur;
  // Inputs reopen as soon as enable is seen high, without waiting for state
  assign buf_en = cke_cur || !(dev_q == sdbk_pkg::dev_power_down ||
                               dev_q == sdbk_pkg::dev_self_refresh);
  assign cmd = buf_en ? sdbk_pkg::cmd_decode(pin_s2_q[6], pin_s2_q[5], pin_s2_q[4], pin_s2_q[3])
                      : sdbk_pkg::deselect_cmd;
  assign all_idle  = (&bank_idle) && (dev_q == sdbk_pkg::dev_normal);
  assign bank_run  = ck_both && (dev_q == sdbk_pkg::dev_normal);
  assign bank_tick = (dev_q != sdbk_pkg::dev_suspend);

  always_comb begin
    dev_d = dev_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    ill_d = 1'b0;
    unique case (dev_q)
      sdbk_pkg::dev_normal: begin
        if (!cke_cur) begin
          if (all_idle) begin
            dev_d = (ck_fall && cmd == sdbk_pkg::refresh_cmd) ? sdbk_pkg::dev_self_refresh
                                                              : sdbk_pkg::dev_power_down;
          end else if (ck_fall) begin
            dev_d = sdbk_pkg::dev_suspend;
          end
        end else if (ck_both && (cmd == sdbk_pkg::refresh_cmd ||
                                 cmd == sdbk_pkg::mode_register_load_cmd)) begin
          if (!all_idle) begin
            ill_d = 1'b1;
          end else if (cmd == sdbk_pkg::refresh_cmd) begin
            dev_d = sdbk_pkg::dev_refresh;
            tmr_d = RC_LOAD;
          end else begin
            dev_d = sdbk_pkg::dev_mode_load;
            tmr_d = ML_LOAD;
          end
        end
      end
      sdbk_pkg::dev_refresh: begin
        ill_d = ck_both && !sdbk_pkg::cmd_quiet(cmd, 1'b1);
        if (tmr_q == '0) begin
          dev_d = sdbk_pkg::dev_normal;
        end
      end
      sdbk_pkg::dev_mode_load: begin
        ill_d = ck_both && !sdbk_pkg::cmd_quiet(cmd, 1'b0);
        if (tmr_q == '0) begin
          dev_d = sdbk_pkg::dev_normal;
        end
      end
      sdbk_pkg::dev_power_down: begin
        if (cke_cur) begin
          dev_d = sdbk_pkg::dev_normal;
        end
      end
      sdbk_pkg::dev_self_refresh: begin
        if (cke_cur) begin
          ill_d = !sdbk_pkg::cmd_quiet(cmd, 1'b1);
          dev_d = sdbk_pkg::dev_sr_recovery;
          tmr_d = RC_LOAD;
        end
      end
      sdbk_pkg::dev_sr_recovery: begin
        ill_d = cke_cur && !sdbk_pkg::cmd_quiet(cmd, 1'b1);
        if (tmr_q == '0) begin
          dev_d = sdbk_pkg::dev_normal;
        end
      end
      sdbk_pkg::dev_suspend: begin
        if (cke_cur) begin
          dev_d = sdbk_pkg::dev_normal;
        end
      end
      default: dev_d = sdbk_pkg::dev_normal;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dev_q <= sdbk_pkg::dev_normal;
      tmr_q <= '0;
      ill_q <= 1'b0;
    end else begin
      dev_q <= dev_d;
      tmr_q <= tmr_d;
      ill_q <= ill_d;
    end
  end

  // One tracker per bank; an all-banks close or a halt (no bank address) reaches every bank
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    sdbk_pkg::sdbk_bank_st_t st;
    logic                    hit;
    assign hit = (cmd == sdbk_pkg::bank_close_cmd && pin_s2_q[0]) ||
                 (cmd == sdbk_pkg::burst_halt_cmd) ||
                 (pin_s2_q[2:1] == sdbk_pkg::BANK_W'(b));
    sdbk_bank u_bank (
      .mclk_i       (mclk_i),
      .nrst_i       (nrst_i),
      .cmd_i        (cmd),
      .hit_i        (hit),
      .auto_close_i (pin_s2_q[0]),
      .run_i        (bank_run),
      .tick_i       (bank_tick),
      .state_o      (st),
      .idle_o       (bank_idle[b]),
      .illegal_o    (bank_ill[b])
    );
    assign bank_state_o[b*sdbk_pkg::ST_W +: sdbk_pkg::ST_W] = st;
  end

  assign dev_state_o     = dev_q;
  assign input_buf_en_o  = buf_en;
  assign clock_suspend_o = (dev_q == sdbk_pkg::dev_suspend);
  assign illegal_cmd_o   = ill_q || (|bank_ill);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_mode_hold;
    (dev_q == sdbk_pkg::dev_mode_load) [*2] ##1 (dev_q == sdbk_pkg::dev_normal);
  endsequence
  sequence s_go_normal;
    dev_q == sdbk_pkg::dev_normal && ck_both && all_idle;
  endsequence

  AST_MODE_LOAD_2CLK: assert property (
    s_go_normal and cmd == sdbk_pkg::mode_register_load_cmd |=> s_mode_hold)
    else $error("mode load did not last two clocks");
  AST_REFRESH_ROW_CYCLE: assert property (
    s_go_normal and cmd == sdbk_pkg::refresh_cmd
    |=> dev_q == sdbk_pkg::dev_refresh ##RC_BACK dev_q == sdbk_pkg::dev_normal)
    else $error("auto refresh did not end after row cycle");
  AST_AUTO_REFRESH: assert property (
    s_go_normal and cmd == sdbk_pkg::refresh_cmd |=> dev_q == sdbk_pkg::dev_refresh)
    else $error("refresh command did not start auto refresh");
  AST_NO_ACT_WITHOUT_CKE: assert property (
    dev_q == sdbk_pkg::dev_normal && !cke_prev_q && cke_cur |=> dev_q == sdbk_pkg::dev_normal)
    else $error("command acted with clock enable low last cycle");
  AST_POWER_DOWN_ENTRY: assert property (
    all_idle && ck_fall && cmd != sdbk_pkg::refresh_cmd
    |=> dev_q == sdbk_pkg::dev_power_down ##1 (!input_buf_en_o || cke_cur))
    else $error("power down not entered with inputs off");
  AST_SELF_REFRESH_ENTRY: assert property (
    all_idle && ck_fall && cmd == sdbk_pkg::refresh_cmd |=> dev_q == sdbk_pkg::dev_self_refresh)
    else $error("self refresh not entered");
  AST_SELF_REFRESH_EXIT: assert property (
    dev_q == sdbk_pkg::dev_self_refresh && cke_cur
    |=> dev_q == sdbk_pkg::dev_sr_recovery ##RC_BACK dev_q == sdbk_pkg::dev_normal)
    else $error("self refresh recovery not one row cycle");
  AST_SUSPEND: assert property (
    dev_q == sdbk_pkg::dev_normal && !all_idle && ck_fall
    |=> clock_suspend_o)
    else $error("clock suspend not entered");
  AST_POWER_DOWN_EXIT: assert property (
    dev_q == sdbk_pkg::dev_power_down && cke_cur |=> dev_q == sdbk_pkg::dev_normal)
    else $error("power down did not exit on rising enable");
  AST_INPUTS_REOPEN: assert property (
    cke_cur |-> input_buf_en_o)
    else $error("inputs stay off with enable high");

endmodule

//--- hdl/sdbk_pkg.sv
// Shared constants, types and decode helpers for the bank state block.
// Assumes a single 40 MHz clock; all times are converted to whole cycles here.
package sdbk_pkg;

  localparam int CLK_MHZ                    = 40;
  localparam int NUM_BANKS                  = 4;
  localparam int BANK_W                     = 2;
  localparam int TMR_W                      = 4;
  localparam int ST_W                       = 3;
  localparam int WRITE_RECOVERY_TIME_NS     = 15;
  localparam int ROW_CYCLE_TIME_NS          = 60;
  localparam int PRECHARGE_TIME_NS          = 18;
  localparam int MODE_LOAD_CYC              = 2;

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int min_cycles(input int t_ns);
    int c;
    c = (t_ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WR_CYC  = min_cycles(WRITE_RECOVERY_TIME_NS);
  localparam int RC_CYC  = min_cycles(ROW_CYCLE_TIME_NS);
  localparam int PRE_CYC = min_cycles(PRECHARGE_TIME_NS);

  typedef enum logic [3:0] {
    deselect_cmd, no_op_cmd, burst_halt_cmd, column_read_cmd, column_write_cmd,
    bank_open_cmd, bank_close_cmd, refresh_cmd, mode_register_load_cmd
  } sdbk_cmd_t;

  typedef enum logic [2:0] {
    bank_idle, bank_active, bank_wr_rec, bank_wr_rec_close, bank_closing
  } sdbk_bank_st_t;

  typedef enum logic [2:0] {
    dev_normal, dev_refresh, dev_mode_load, dev_power_down,
    dev_self_refresh, dev_sr_recovery, dev_suspend
  } sdbk_dev_st_t;

  function automatic sdbk_cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
    if (cs_n) begin
      return deselect_cmd;
    end
    unique case ({ras_n, cas_n, we_n})
      3'h7: return no_op_cmd;
      3'h6: return burst_halt_cmd;
      3'h5: return column_read_cmd;
      3'h4: return column_write_cmd;
      3'h3: return bank_open_cmd;
      3'h2: return bank_close_cmd;
      3'h1: return refresh_cmd;
      3'h0: return mode_register_load_cmd;
    endcase
  endfunction

  // Commands that only pass time; burst halt optionally among them
  function automatic logic cmd_quiet(input sdbk_cmd_t c, input logic halt_ok);
    return (c == deselect_cmd) || (c == no_op_cmd) || (halt_ok && c == burst_halt_cmd);
  endfunction

endpackage

//--- hdl/sdbk_bank.sv
// One bank: state and remaining time, advanced by commands aimed at it.
// Assumes commands arrive decoded and already qualified by clock enable.
`timescale 1ns/1ps
module sdbk_bank (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     nrst_i,
  // Command
  input  wire sdbk_pkg::sdbk_cmd_t      cmd_i,
  input  wire logic                     hit_i,
  input  wire logic                     auto_close_i,
  input  wire logic                     run_i,
  input  wire logic                     tick_i,
  // Status
  output sdbk_pkg::sdbk_bank_st_t       state_o,
  output logic                          idle_o,
  output logic                          illegal_o
);

  sdbk_pkg::sdbk_bank_st_t st_q, st_d;
  logic [sdbk_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic                       halt_q, halt_d;
  logic                       ill_q, ill_d;
  sdbk_pkg::sdbk_cmd_t        c;
  logic                       expire;

  localparam logic [sdbk_pkg::TMR_W-1:0] WR_LOAD  = sdbk_pkg::TMR_W'(sdbk_pkg::WR_CYC - 1);
  localparam logic [sdbk_pkg::TMR_W-1:0] PRE_LOAD = sdbk_pkg::TMR_W'(sdbk_pkg::PRE_CYC - 1);

  always_comb begin
    // Commands for other banks are no-ops here
    c      = (run_i && hit_i) ? cmd_i : sdbk_pkg::no_op_cmd;
    expire = tick_i && (tmr_q == '0);
    st_d   = st_q;
    tmr_d  = (tick_i && tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    halt_d = halt_q;
    ill_d  = 1'b0;
    unique case (st_q)
      sdbk_pkg::bank_idle: begin
        if (c == sdbk_pkg::bank_open_cmd) begin
          st_d = sdbk_pkg::bank_active;
        end else if (c == sdbk_pkg::column_read_cmd || c == sdbk_pkg::column_write_cmd) begin
          ill_d = 1'b1;
        end
      end
      sdbk_pkg::bank_active: begin
        if (c == sdbk_pkg::column_write_cmd) begin
          st_d   = auto_close_i ? sdbk_pkg::bank_wr_rec_close : sdbk_pkg::bank_wr_rec;
          tmr_d  = WR_LOAD;
          halt_d = 1'b0;
        end else if (c == sdbk_pkg::bank_close_cmd) begin
          st_d  = sdbk_pkg::bank_closing;
          tmr_d = PRE_LOAD;
        end else if (c == sdbk_pkg::bank_open_cmd) begin
          ill_d = 1'b1;
        end
      end
      sdbk_pkg::bank_wr_rec: begin
        if (c == sdbk_pkg::column_read_cmd) begin
          st_d = sdbk_pkg::bank_active;
        end else if (c == sdbk_pkg::column_write_cmd) begin
          st_d  = auto_close_i ? sdbk_pkg::bank_wr_rec_close : sdbk_pkg::bank_wr_rec;
          tmr_d = WR_LOAD;
        end else if (c == sdbk_pkg::bank_open_cmd || c == sdbk_pkg::bank_close_cmd) begin
          ill_d = 1'b1;
        end else if (expire) begin
          st_d = sdbk_pkg::bank_active;
        end
      end
      sdbk_pkg::bank_wr_rec_close: begin
        if (c == sdbk_pkg::burst_halt_cmd) begin
          halt_d = 1'b1;
        end
        if (c == sdbk_pkg::column_read_cmd || c == sdbk_pkg::column_write_cmd ||
            c == sdbk_pkg::bank_open_cmd || c == sdbk_pkg::bank_close_cmd) begin
          ill_d = 1'b1;
        end else if (expire) begin
          halt_d = 1'b0;
          if (halt_q || c == sdbk_pkg::burst_halt_cmd) begin
            st_d = sdbk_pkg::bank_active;
          end else begin
            st_d  = sdbk_pkg::bank_closing;
            tmr_d = PRE_LOAD;
          end
        end
      end
      sdbk_pkg::bank_closing: begin
        if (c == sdbk_pkg::column_read_cmd || c == sdbk_pkg::column_write_cmd ||
            c == sdbk_pkg::bank_open_cmd) begin
          ill_d = 1'b1;
        end else if (expire) begin
          st_d = sdbk_pkg::bank_idle;
        end
      end
      default: st_d = sdbk_pkg::bank_idle;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_q   <= sdbk_pkg::bank_idle;
      tmr_q  <= '0;
      halt_q <= 1'b0;
      ill_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      halt_q <= halt_d;
      ill_q  <= ill_d;
    end
  end

  assign state_o   = st_q;
  assign idle_o    = (st_q == sdbk_pkg::bank_idle);
  assign illegal_o = ill_q;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_WR_REC_DONE: assert property (
    st_q == sdbk_pkg::bank_wr_rec && expire && !(run_i && hit_i)
    |=> st_q == sdbk_pkg::bank_active)
    else $error("write recovery did not return to active");
  AST_WR_CLOSE_DONE: assert property (
    st_q == sdbk_pkg::bank_wr_rec_close && expire && !halt_q && !(run_i && hit_i)
    |=> st_q == sdbk_pkg::bank_closing)
    else $error("write recovery with close did not start closing");
  AST_CLOSE_DONE: assert property (
    st_q == sdbk_pkg::bank_closing && expire && !(run_i && hit_i)
    |=> st_q == sdbk_pkg::bank_idle)
    else $error("closing bank did not reach idle");
  AST_OTHER_BANK: assert property (
    !hit_i && !expire && st_q != sdbk_pkg::bank_idle |=> $stable(st_q))
    else $error("bank changed state on a command for another bank");

endmodule

//--- verification/sdbk_ctl_model.sv
// Memory controller model driving the clock-enable and command pins of the bank block.
// Assumes the bench calls issue at most once per cycle; pins change at rising edges.
`timescale 1ns/1ps
module sdbk_ctl_model (
  // Clock
  input  wire logic       mclk_i,
  // Command pins
  output logic            cke_o,
  output logic            cs_n_o,
  output logic            ras_n_o,
  output logic            cas_n_o,
  output logic            we_n_o,
  output logic [1:0]      ba_o,
  output logic            flag_o
);
  sdbk_pkg::sdbk_cmd_t p_cmd;
  logic [1:0]          p_ba;
  logic                p_f;
  logic                p_v;
  logic                p_cke;
  logic [3:0]          open_q;

  function automatic logic [2:0] enc(input sdbk_pkg::sdbk_cmd_t c);
    case (c)
      sdbk_pkg::burst_halt_cmd:         return 3'h6;
      sdbk_pkg::column_read_cmd:        return 3'h5;
      sdbk_pkg::column_write_cmd:       return 3'h4;
      sdbk_pkg::bank_open_cmd:          return 3'h3;
      sdbk_pkg::bank_close_cmd:         return 3'h2;
      sdbk_pkg::refresh_cmd:            return 3'h1;
      sdbk_pkg::mode_register_load_cmd: return 3'h0;
      default:                          return 3'h7;
    endcase
  endfunction

  initial begin
    p_v = 1'b0;
    p_cke = 1'b1;
    open_q = 4'h0;
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, flag_o} = 7'h7F;
  end

  task automatic issue(input sdbk_pkg::sdbk_cmd_t c, input logic [1:0] b, input logic f,
                       input logic k);
    @(negedge mclk_i);
    // Refresh code with enable falling only goes out with every bank closed
    p_cmd = (!k && p_cke && open_q != 4'h0 && c == sdbk_pkg::refresh_cmd) ?
            sdbk_pkg::no_op_cmd : c;
    p_ba = b;
    p_f = f;
    p_cke = k;
    p_v = 1'b1;
    @(posedge mclk_i);
    #1;
  endtask

  always @(posedge mclk_i) begin
    cke_o <= p_cke;
    if (p_v && p_cmd != sdbk_pkg::deselect_cmd) begin
      cs_n_o <= 1'b0;
      {ras_n_o, cas_n_o, we_n_o} <= enc(p_cmd);
      ba_o <= p_ba;
      flag_o <= p_f;
    end else begin
      // Deselected lines carry noise so nothing leans on stale values
      cs_n_o <= 1'b1;
      {ras_n_o, cas_n_o, we_n_o, ba_o, flag_o} <= 6'($urandom);
    end
    if (p_v && p_cke) begin
      if (p_cmd == sdbk_pkg::bank_open_cmd)
        open_q[p_ba] <= 1'b1;
      else if (p_cmd == sdbk_pkg::bank_close_cmd && p_f)
        open_q <= 4'h0;
      else if (p_cmd == sdbk_pkg::bank_close_cmd || (p_cmd == sdbk_pkg::column_write_cmd && p_f))
        open_q[p_ba] <= 1'b0;
    end
    p_v = 1'b0;
  end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the bank state and clock-enable block.
// Assumes the controller model on the pins and a 40 MHz clock.
`timescale 1ns/1ps
module tb_top;
  logic                   mclk_i;
  logic                   nrst_i;
  logic                   cke;
  logic                   cs_n;
  logic                   ras_n;
  logic                   cas_n;
  logic                   we_n;
  logic [1:0]             ba;
  logic                   flag;
  logic [11:0]            bank_st;
  sdbk_pkg::sdbk_dev_st_t dev_st;
  logic                   buf_en;
  logic                   susp;
  logic                   illegal;
  int                     error_cnt = 0;
  int                     samples_checked = 0;
  int                     cyc = 0;
  sdbk_pkg::sdbk_cmd_t    bad [4];

  sdbk_ctrl i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba),
    .auto_close_flag_pin_i(flag), .bank_state_o(bank_st), .dev_state_o(dev_st),
    .input_buf_en_o(buf_en), .clock_suspend_o(susp), .illegal_cmd_o(illegal));

  sdbk_ctl_model i_ctl (.mclk_i(mclk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n),
    .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .flag_o(flag));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  function automatic logic [11:0] at(input int b, input logic [2:0] s);
    return 12'(s) << (3 * b);
  endfunction

  function automatic logic [2:0] exp_wr(input logic f, input int d);
    if (d <= sdbk_pkg::WR_CYC)
      return f ? sdbk_pkg::bank_wr_rec_close : sdbk_pkg::bank_wr_rec;
    if (!f)
      return sdbk_pkg::bank_active;
    if (d <= sdbk_pkg::WR_CYC + sdbk_pkg::PRE_CYC)
      return sdbk_pkg::bank_closing;
    return sdbk_pkg::bank_idle;
  endfunction

  function automatic logic [2:0] exp_tm(input int m, input int d);
    if (m == 0 && d <= sdbk_pkg::RC_CYC)
      return sdbk_pkg::dev_refresh;
    if (m == 1 && d <= sdbk_pkg::MODE_LOAD_CYC)
      return sdbk_pkg::dev_mode_load;
    return sdbk_pkg::dev_normal;
  endfunction

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic cmd(input sdbk_pkg::sdbk_cmd_t c, input int b, input logic f,
                     input logic k = 1'b1);
    i_ctl.issue(c, 2'(b), f, k);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      $display("BAD run length expected under 3000 seen 3000");
      complete_run();
    end
  end

  initial begin
    logic                   f;
    int                     r;
    sdbk_pkg::sdbk_dev_st_t z;
    nrst_i = 1'b0;
    bad = '{sdbk_pkg::column_read_cmd, sdbk_pkg::column_write_cmd,
            sdbk_pkg::bank_open_cmd, sdbk_pkg::bank_close_cmd};
    void'($urandom(32'h5fa6));
    step(3);
    chk("reset banks", 12'h000, bank_st);
    chk("reset flags", 12'h004, {6'h0, dev_st, buf_en, susp, illegal});
    @(posedge mclk_i);
    nrst_i <= 1'b1;
    step(6);
    for (int b = 0; b < 4; b++) begin
      f = 1'($urandom);
      cmd(sdbk_pkg::bank_open_cmd, b, 1'b0);
      step(4);
      chk("open", at(b, sdbk_pkg::bank_active), bank_st);
      cmd(sdbk_pkg::column_write_cmd, b, f);
      for (int d = 1; d <= 3; d++) begin
        step(d == 1 ? 3 : 1);
        chk("write", at(b, exp_wr(f, d)), bank_st);
      end
      cmd(sdbk_pkg::bank_close_cmd, b, 1'b0);
      step(3);
      chk("close", at(b, f ? sdbk_pkg::bank_idle : sdbk_pkg::bank_closing), bank_st);
      step(1);
      chk("closed", 12'h000, bank_st);
    end
    $display("write recovery test done");
    r = $urandom_range(3);
    cmd(sdbk_pkg::bank_open_cmd, r, 1'b0);
    step(4);
    cmd(sdbk_pkg::column_write_cmd, r, 1'b1);
    cmd(sdbk_pkg::burst_halt_cmd, 0, 1'b0);
    step(2);
    chk("halt rec", at(r, sdbk_pkg::bank_wr_rec_close), bank_st);
    step(1);
    chk("halt act", at(r, sdbk_pkg::bank_active), bank_st);
    cmd(sdbk_pkg::column_write_cmd, r, 1'b0);
    cmd(sdbk_pkg::column_write_cmd, r, 1'b1);
    step(2);
    chk("rec write", at(r, sdbk_pkg::bank_wr_rec), bank_st);
    step(1);
    chk("rewrite", at(r, sdbk_pkg::bank_wr_rec_close), bank_st);
    cmd(sdbk_pkg::bank_close_cmd, r, 1'b0);
    step(5);
    $display("burst halt test done");
    foreach (bad[i]) begin
      cmd(sdbk_pkg::bank_open_cmd, 1, 1'b0);
      step(4);
      cmd(sdbk_pkg::column_write_cmd, 1, 1'b1);
      cmd(bad[i], 1, 1'b0);
      step(3);
      chk("illegal", 12'h001, {11'h0, illegal});
      step(1);
      chk("ignored", at(1, sdbk_pkg::bank_closing), bank_st);
      step(2);
    end
    cmd(sdbk_pkg::bank_close_cmd, 0, 1'b1);
    $display("illegal command test done");
    for (int m = 0; m < 2; m++) begin
      cmd(m ? sdbk_pkg::mode_register_load_cmd : sdbk_pkg::refresh_cmd, 0, 1'b0);
      cmd(m ? sdbk_pkg::burst_halt_cmd : sdbk_pkg::column_read_cmd, 0, 1'b0);
      for (int d = 1; d <= 4; d++) begin
        step(d == 1 ? 2 : 1);
        chk("timed", {8'h0, exp_tm(m, d), 1'(d == 2)}, {8'h0, dev_st, illegal});
      end
    end
    $display("refresh and mode load test done");
    for (int s = 0; s < 3; s++) begin
      z = s ? sdbk_pkg::dev_self_refresh : sdbk_pkg::dev_power_down;
      cmd(s ? sdbk_pkg::refresh_cmd : sdbk_pkg::deselect_cmd, 0, 1'b0, 1'b0);
      step(4);
      chk("sleep", {8'h0, z, 1'b0}, {8'h0, dev_st, buf_en});
      cmd(sdbk_pkg::column_write_cmd, 0, 1'b0, 1'b0);
      step(4);
      chk("hold", {7'h0, z, 2'h0}, {7'h0, dev_st, buf_en, illegal});
      cmd(s == 2 ? sdbk_pkg::column_read_cmd : sdbk_pkg::no_op_cmd, 0, 1'b0);
      step(2);
      chk("wake", {7'h0, z, 2'h2}, {7'h0, dev_st, buf_en, illegal});
      step(1);
      z = s ? sdbk_pkg::dev_sr_recovery : sdbk_pkg::dev_normal;
      chk("exit", {7'h0, z, 1'b1, 1'(s == 2)}, {7'h0, dev_st, buf_en, illegal});
      step(3);
      chk("idle", 12'h002, {7'h0, dev_st, buf_en, illegal});
    end
    $display("power down test done");
    cmd(sdbk_pkg::bank_open_cmd, 3, 1'b0);
    step(4);
    cmd(sdbk_pkg::deselect_cmd, 0, 1'b0, 1'b0);
    step(4);
    chk("suspend", {8'h0, sdbk_pkg::dev_suspend, 1'b1}, {8'h0, dev_st, susp});
    cmd(sdbk_pkg::bank_close_cmd, 3, 1'b0, 1'b0);
    cmd(sdbk_pkg::deselect_cmd, 0, 1'b0);
    step(4);
    chk("resume", {8'h0, sdbk_pkg::dev_normal, 1'b0}, {8'h0, dev_st, susp});
    chk("held", at(3, sdbk_pkg::bank_active), bank_st);
    cmd(sdbk_pkg::bank_close_cmd, 3, 1'b0);
    step(5);
    chk("final", 12'h000, bank_st);
    $display("clock suspend test done");
    complete_run();
  end
endmodule
